// File: verilog/masc_top.sv
// Operation
// - address bits taken on input clock rise
// - all-zero address keeps previous channel
// - select high: shift address, no switching
// - select low connects chosen channel
// - cycle conversion, sleep, output, repeat
// - sleep while converter select stays high
// - result held unchanged during sleep
// - converter select high: output high impedance
// - conversion and sleep show done status
// - output bit changes on shift clock fall
// - output ends after 32 bits or select
// - select rise in output aborts, converts
// - word belongs to conversion just finished
// - tied notch pin picks 50 or 60Hz
// - toggling notch pin is conversion clock
// - shift mode from pins, no register
// - calibration each cycle, timing unchanged
// - power-on pulse clears state, then converts
// - all channels off after reset
// - word: done, zero, sign, range, data, sub
// - output high after 32nd falling clock
// - address is enable plus channel number
`timescale 1ns/1ps
`default_nettype none

module masc_top #(
    parameter int CONV_50HZ_CYC = masc_pkg::CONV_50HZ_CYC, // 50 Hz notch conversion
    parameter int CONV_60HZ_CYC = masc_pkg::CONV_60HZ_CYC, // 60 Hz notch conversion
    parameter int POR_CYC       = masc_pkg::POR_CYC,       // power-on pulse
    parameter int EXT_IDLE_CYC  = masc_pkg::EXT_IDLE_CYC   // notch pin idle timeout
) (
    input  wire logic                   ref_clk,            // 50 MHz clock
    input  wire logic                   nrst,               // async reset, active low
    input  wire logic                   psel,               // apb select
    input  wire logic                   penable,            // apb enable
    input  wire logic                   pwrite,             // apb write
    input  wire logic [7:0]             paddr,              // apb byte address
    input  wire logic [31:0]            pwdata,             // apb write data
    output logic      [31:0]            prdata,             // apb read data
    output logic                        pready,             // apb ready
    output logic                        pslverr,            // apb error
    input  wire logic                   converter_select_n, // converter select pin
    input  wire logic                   mux_select_n,       // mux select pin
    input  wire logic                   out_shift_clk,      // output shift clock pin
    input  wire logic                   in_shift_clk,       // input shift clock pin
    input  wire logic                   address_in,         // serial address pin
    input  wire logic                   notch_select,       // notch level or ext clock
    input  wire masc_pkg::masc_sample_s sample,             // front end sample
    output logic                        serial_out,         // serial data out
    output logic                        serial_out_oe_n,    // low while driving
    output logic                        mux_output_en,      // channel switched through
    output logic      [2:0]             mux_output_chan,    // switched channel number
    output logic                        conv_active         // modulator running
);

    // pin synchronisers: s1 feeds s2 only, s3 for edges
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [5:0] pin_s3;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1 <= 6'h31; // idle pin levels, no false edge
            pin_s2 <= 6'h31;
            pin_s3 <= 6'h31;
        end else begin
            pin_s1 <= {converter_select_n, mux_select_n, out_shift_clk,
                       in_shift_clk, address_in, notch_select};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    function automatic logic rose(logic now, logic prev);
        return now & ~prev;
    endfunction

    // named pin levels and edges
    wire cs_s      = pin_s2[5];
    wire cs_rise   = rose(pin_s2[5], pin_s3[5]);
    wire msel_s    = pin_s2[4];
    wire msel_fall = rose(pin_s3[4], pin_s2[4]);
    wire sck_fall  = rose(pin_s3[3], pin_s2[3]);
    wire iclk_rise = rose(pin_s2[2], pin_s3[2]);
    wire din_s     = pin_s2[1];
    wire notch_s   = pin_s2[0];
    wire notch_rise = rose(pin_s2[0], pin_s3[0]);
    wire notch_edge = pin_s2[0] ^ pin_s3[0];

    // power-on pulse after reset release
    logic [15:0] por_cnt;
    logic        por_busy;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            por_cnt  <= 16'h0000;
            por_busy <= 1'b1;
        end else if (por_busy) begin
            por_cnt  <= por_cnt + 16'h0001;
            por_busy <= (por_cnt != 16'(POR_CYC - 1));
        end
    end

    // external clock detect on notch pin
    logic [15:0] idle_cnt;
    logic        ext_mode;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt <= 16'h0000;
            ext_mode <= 1'b0;
        end else if (notch_edge && !por_busy) begin
            idle_cnt <= 16'h0000;
            ext_mode <= 1'b1;
        end else if (idle_cnt == 16'(EXT_IDLE_CYC - 1)) begin
            ext_mode <= 1'b0;
        end else begin
            idle_cnt <= idle_cnt + 16'h0001;
        end
    end

    // channel address path
    masc_pkg::masc_mux_s chan_sel;
    logic                connect;

    masc_mux u_mux (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .clear    (por_busy),
        .clk_rise (iclk_rise),
        .sel_high (msel_s),
        .sel_fall (msel_fall),
        .din      (din_s),
        .chan_sel (chan_sel),
        .connect  (connect)
    );

    // conversion length from notch pin level or ext clock
    masc_pkg::masc_state_e state;
    logic [23:0]           conv_cnt;
    logic [31:0]           out_sr;
    logic [4:0]            bit_cnt;
    logic [23:0]           offset;
    logic [31:0]           result;
    logic                  result_valid;

    wire [23:0] conv_last = notch_s ? 24'(CONV_50HZ_CYC - 1)
                                    : 24'(CONV_60HZ_CYC - 1);
    wire        conv_tick = ext_mode ? notch_rise : 1'b1;
    wire [23:0] tick_last = ext_mode ? 24'(masc_pkg::EXT_CONV_EDGES - 1) : conv_last;
    wire        conv_done = (state == masc_pkg::ST_CONV) && conv_tick && (conv_cnt >= tick_last);
    wire [23:0] corrected = sample.result - offset;
    wire [31:0] new_word  = masc_pkg::masc_pack(sample, corrected);
    wire        word_end  = sck_fall && (bit_cnt == masc_pkg::LAST_BIT);

    // cycle: convert, sleep, output; shift mode needs no setting
    masc_pkg::masc_state_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            masc_pkg::ST_CONV: begin
                if (conv_done) begin
                    next_state = masc_pkg::ST_SLEEP;
                end
            end
            masc_pkg::ST_SLEEP: begin
                if (!cs_s) begin
                    next_state = masc_pkg::ST_OUT;
                end
            end
            masc_pkg::ST_OUT: begin
                if (cs_rise || word_end) begin
                    next_state = masc_pkg::ST_CONV;
                end
            end
            default: begin
                next_state = masc_pkg::ST_CONV;
            end
        endcase
    end

    // state and conversion counter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state    <= masc_pkg::ST_CONV;
            conv_cnt <= 24'h000000;
        end else if (por_busy) begin
            state    <= masc_pkg::ST_CONV;
            conv_cnt <= 24'h000000;
        end else begin
            state <= next_state;
            if (state != masc_pkg::ST_CONV || conv_done) begin
                conv_cnt <= 24'h000000;
            end else if (conv_tick) begin
                conv_cnt <= conv_cnt + 24'h000001;
            end
        end
    end

    // output shift register, loaded from the conversion just done
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_sr       <= masc_pkg::WORD_RST;
            bit_cnt      <= 5'h00;
            result       <= masc_pkg::WORD_RST;
            result_valid <= 1'b0;
        end else if (por_busy) begin
            out_sr       <= masc_pkg::WORD_RST;
            bit_cnt      <= 5'h00;
            result       <= masc_pkg::WORD_RST;
            result_valid <= 1'b0;
        end else if (conv_done) begin
            out_sr       <= new_word;
            result       <= new_word;
            result_valid <= connect;
            bit_cnt      <= 5'h00;
        end else if (state == masc_pkg::ST_OUT && sck_fall) begin
            out_sr  <= {out_sr[30:0], 1'b1};
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // serial output value and enable
    logic next_sdo;

    always_comb begin
        case (state)
            masc_pkg::ST_CONV:  next_sdo = 1'b1;
            masc_pkg::ST_SLEEP: next_sdo = 1'b0;
            default:            next_sdo = out_sr[31];
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            serial_out      <= 1'b1;
            serial_out_oe_n <= 1'b1;
            mux_output_en   <= 1'b0;
            mux_output_chan <= 3'h0;
            conv_active     <= 1'b0;
        end else begin
            serial_out      <= next_sdo;
            serial_out_oe_n <= cs_s;
            mux_output_en   <= connect;
            mux_output_chan <= chan_sel.chan;
            conv_active     <= (state == masc_pkg::ST_CONV) && !por_busy;
        end
    end

    // apb decode
    wire hit_off  = (paddr == masc_pkg::REG_OFFSET);
    wire hit_stat = (paddr == masc_pkg::REG_STATUS);
    wire hit_res  = (paddr == masc_pkg::REG_RESULT);
    wire mapped   = hit_off | hit_stat | hit_res;
    wire apb_acc  = psel & penable & ~pready;
    wire apb_wr   = psel & penable & pready & pwrite & hit_off;

    wire [31:0] status_word = {23'h000000, por_busy, result_valid, chan_sel.chan,
                               chan_sel.enable, ext_mode, 2'(state)};
    wire [31:0] rd_data = hit_off  ? {8'h00, offset} :
                          hit_stat ? status_word :
                          hit_res  ? result : 32'h00000000;

    // apb slave, one wait state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            offset  <= masc_pkg::OFFSET_RST;
        end else begin
            pready <= apb_acc;
            if (apb_acc) begin
                prdata  <= pwrite ? 32'h00000000 : rd_data;
                pslverr <= ~mapped;
            end
            if (apb_wr) begin
                offset <= pwdata[23:0];
            end
        end
    end

    a_sdo_hiz: assert property (@(posedge ref_clk) disable iff (!nrst)
        cs_s [*2] |-> serial_out_oe_n)
        else $error("serial output driven while select high");

    a_sleep_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        state == masc_pkg::ST_SLEEP && $past(state) == masc_pkg::ST_SLEEP |-> $stable(out_sr))
        else $error("result changed during sleep");

    a_sleep_stays: assert property (@(posedge ref_clk) disable iff (!nrst)
        state == masc_pkg::ST_SLEEP && cs_s && !por_busy |=> state == masc_pkg::ST_SLEEP)
        else $error("left sleep with select high");

    a_abort_conv: assert property (@(posedge ref_clk) disable iff (!nrst)
        state == masc_pkg::ST_OUT && cs_rise && !por_busy |=> state == masc_pkg::ST_CONV)
        else $error("select rise did not abort output");

    a_word_end_high: assert property (@(posedge ref_clk) disable iff (!nrst)
        state == masc_pkg::ST_OUT && word_end && !por_busy
        |=> state == masc_pkg::ST_CONV ##1 serial_out)
        else $error("no high after last falling clock");

    a_cycle_order: assert property (@(posedge ref_clk) disable iff (!nrst)
        state == masc_pkg::ST_SLEEP && $past(state) != masc_pkg::ST_SLEEP
        |-> $past(state) == masc_pkg::ST_CONV)
        else $error("sleep not entered from conversion");

    a_status_shown: assert property (@(posedge ref_clk) disable iff (!nrst)
        state == masc_pkg::ST_SLEEP ##1 state == masc_pkg::ST_SLEEP |-> !serial_out)
        else $error("done status not low in sleep");

    a_por_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
        por_busy ##1 por_busy |-> state == masc_pkg::ST_CONV && conv_cnt == 24'h000000)
        else $error("state moved during power-on pulse");

    a_word_format: assert property (@(posedge ref_clk) disable iff (!nrst)
        conv_done && !por_busy |=> out_sr[31:30] == 2'b00
        && out_sr[27:4] == $past(sample.result) - $past(offset))
        else $error("output word not built from this conversion");

endmodule

`default_nettype wire

// File: include/masc_pkg.sv
`default_nettype none

package masc_pkg;

    // clock and timing, times in microseconds
    localparam int CLK_MHZ       = 50;
    localparam int CONV_50HZ_US  = 160000;
    localparam int CONV_60HZ_US  = 133330;
    localparam int POR_US        = 500;
    localparam int EXT_IDLE_US   = 1000;
    localparam int CONV_50HZ_CYC = CONV_50HZ_US * CLK_MHZ;
    localparam int CONV_60HZ_CYC = CONV_60HZ_US * CLK_MHZ;
    localparam int POR_CYC       = POR_US * CLK_MHZ;
    localparam int EXT_IDLE_CYC  = EXT_IDLE_US * CLK_MHZ;

    // external conversion clock: periods per output word
    localparam int EXT_CONV_EDGES = 20480;
    localparam logic [4:0] LAST_BIT = 5'h1f;

    // register map, byte addresses
    localparam logic [7:0]  REG_OFFSET = 8'h00;
    localparam logic [7:0]  REG_STATUS = 8'h04;
    localparam logic [7:0]  REG_RESULT = 8'h08;
    localparam logic [23:0] OFFSET_RST = 24'h000000;
    localparam logic [31:0] WORD_RST   = 32'h00000000;

    typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_OUT} masc_state_e;

    // raw sample from the modulator front end
    typedef struct packed {
        logic        sign;
        logic        range;
        logic [23:0] result;
        logic [3:0]  sub;
    } masc_sample_s;

    // decoded channel: enable bit then channel number
    typedef struct packed {
        logic       enable;
        logic [2:0] chan;
    } masc_mux_s;

    localparam masc_mux_s MUX_RST = 4'h0;

    // build the serial word: done flag, zero, sign, range, data, sub bits
    function automatic logic [31:0] masc_pack(masc_sample_s s, logic [23:0] corr);
        return {1'b0, 1'b0, s.sign, s.range, corr, s.sub};
    endfunction

endpackage

`default_nettype wire

// File: verilog/masc_mux.sv
`timescale 1ns/1ps
`default_nettype none

module masc_mux (
    input  wire logic                ref_clk,   // system clock
    input  wire logic                nrst,      // async reset, active low
    input  wire logic                clear,     // power-on clear
    input  wire logic                clk_rise,  // input shift clock rose
    input  wire logic                sel_high,  // mux select high, synced
    input  wire logic                sel_fall,  // mux select fell
    input  wire logic                din,       // address bit, synced
    output masc_pkg::masc_mux_s      chan_sel,  // latched channel
    output logic                     connect    // channel switched through
);

    logic [3:0] addr_sr;

    wire        addr_zero = (addr_sr == 4'h0);
    wire        take      = sel_fall & ~addr_zero;

    // address shifter, only while select is high
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            addr_sr <= 4'h0;
        end else if (clear || sel_fall) begin
            addr_sr <= 4'h0;
        end else if (clk_rise && sel_high) begin
            addr_sr <= {addr_sr[2:0], din};
        end
    end

    // channel latch at select fall, zero word keeps old channel
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan_sel <= masc_pkg::MUX_RST;
        end else if (clear) begin
            chan_sel <= masc_pkg::MUX_RST;
        end else if (take) begin
            chan_sel <= addr_sr;
        end
    end

    // switch only while select is low
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            connect <= 1'b0;
        end else begin
            connect <= chan_sel.enable & ~sel_high & ~clear;
        end
    end

    a_zero_keeps_chan: assert property (@(posedge ref_clk) disable iff (!nrst)
        sel_fall && addr_zero && !clear |=> $stable(chan_sel))
        else $error("zero address changed the channel");

    a_high_no_connect: assert property (@(posedge ref_clk) disable iff (!nrst)
        sel_high [*2] |-> !connect)
        else $error("channel connected while select high");

endmodule

`default_nettype wire

// File: bench/masc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module masc_host_model #(
    parameter int HALF = 8 // shift clock half period in ref_clk cycles
) (
    input  wire logic        ref_clk,    // system clock
    input  wire logic        sdo_line,   // resolved serial data line
    output logic             cs_n,       // common select for both pins
    output logic             sck,        // common shift clock
    output logic             din,        // serial address bit
    output logic             word_valid, // one-cycle pulse per word read
    output logic [31:0]      word        // last word read
);
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        din = 1'b0;
        word_valid = 1'b0;
        word = 32'h00000000;
    end

    // wait whole system clock cycles
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // address entry, select low, then nbits read out; select left low
    task automatic frame(input logic [3:0] addr, input int nbits);
        logic [31:0] w;
        w = 32'h00000000;
        for (int k = 3; k >= 0; k--) begin
            din <= addr[k];
            ticks(HALF);
            sck <= 1'b1;
            ticks(HALF);
            sck <= 1'b0;
        end
        ticks(HALF);
        cs_n <= 1'b0;
        din <= ~addr[0];
        ticks(HALF);
        for (int b = 0; b < nbits; b++) begin
            sck <= 1'b1;
            w = {w[30:0], sdo_line};
            din <= ~din;
            ticks(HALF);
            sck <= 1'b0;
            ticks(HALF);
        end
        if (nbits == 32) begin
            word <= w;
            word_valid <= 1'b1;
            ticks(1);
            word_valid <= 1'b0;
        end
    endtask

    // deselect: ends or aborts a read-out
    task automatic release_sel();
        cs_n <= 1'b1;
        ticks(1);
    endtask
endmodule

`default_nettype wire

// File: bench/multiplexed_adc_serial_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module multiplexed_adc_serial_control_test;
    localparam int POR = 20;
    localparam int C50 = 200;
    localparam int C60 = 150;
    logic                   ref_clk, nrst, psel, penable, pwrite, notch, pready, pslverr;
    logic                   sdo, sdo_oe_n, mux_en, conv, cs_n, sck, din, wvalid, en_exp;
    logic [7:0]             paddr;
    logic [31:0]            pwdata, prdata, word, w;
    logic [23:0]            off;
    logic [2:0]             mux_ch, ch_exp;
    logic [3:0]             addrs [4];
    wire                    sdo_line;
    masc_pkg::masc_sample_s sample;
    int                     failures, num_checks, cyc, n, len;
    logic [32:0]            apb_q[$];
    logic [31:0]            msk_q[$], word_q[$];

    assign sdo_line = sdo_oe_n ? 1'bz : sdo;

    masc_top #(.CONV_50HZ_CYC(C50), .CONV_60HZ_CYC(C60), .POR_CYC(POR), .EXT_IDLE_CYC(50)) i_masc_top (
        .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .converter_select_n(cs_n), .mux_select_n(cs_n), .out_shift_clk(sck), .in_shift_clk(sck),
        .address_in(din), .notch_select(notch), .sample(sample), .serial_out(sdo),
        .serial_out_oe_n(sdo_oe_n), .mux_output_en(mux_en), .mux_output_chan(mux_ch), .conv_active(conv)
    );

    masc_host_model i_masc_host_model (
        .ref_clk(ref_clk), .sdo_line(sdo_line), .cs_n(cs_n), .sck(sck), .din(din),
        .word_valid(wvalid), .word(word)
    );

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
        apb_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h00000000);
    endtask

    task automatic wait_conv(input logic v, output int k);
        k = 0;
        while (conv !== v && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
    endtask

    // result watcher: oldest note against each completed result
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite && apb_q.size() > 0) begin
            check("apb read", apb_q[0], {pslverr, prdata & msk_q[0]});
            apb_q.delete(0);
            msk_q.delete(0);
        end
        if (wvalid) begin
            check("serial word", {1'b0, word_q.pop_front()}, {1'b0, word});
        end
    end

    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end

    // main sequence
    initial begin
        void'($urandom(88054));
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        notch = 1'b1;
        sample = 30'($urandom);
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        check("enable after reset", 33'h0, {32'h0, mux_en});
        wait_conv(1'b1, n);
        check("power-on length", 33'h1, {32'h0, n >= POR && n <= POR + 8});
        off = 24'($urandom);
        apb(1'b1, masc_pkg::REG_OFFSET, {8'hff, off});
        rd(masc_pkg::REG_OFFSET, {9'h000, off}, 32'hffffffff);
        rd(8'h0c, {1'b1, 32'h00000000}, 32'hffffffff);
        apb(1'b1, masc_pkg::REG_RESULT, 32'hffffffff);
        $display("test registers done");
        wait_conv(1'b0, n);
        en_exp = 1'b0;
        ch_exp = 3'h0;
        addrs = '{4'h8 | 4'($urandom_range(7)), 4'h0, 4'h5, 4'hc};
        for (int i = 0; i < 4; i++) begin
            rd(masc_pkg::REG_STATUS, 33'h1, 32'h3);
            notch <= i[0];
            repeat (60) @(posedge ref_clk);
            w = {2'b00, sample.sign, sample.range, sample.result - off, sample.sub};
            if (i < 3) word_q.push_back(w);
            i_masc_host_model.frame(addrs[i], i < 3 ? 32 : 10);
            if (i < 3) check("after last bit", 33'h2, {31'h0, sdo, sdo_oe_n});
            if (addrs[i] != 4'h0) begin
                en_exp = addrs[i][3];
                ch_exp = addrs[i][2:0];
            end
            check("channel enable", {32'h0, en_exp}, {32'h0, mux_en});
            if (en_exp) check("channel", {30'h0, ch_exp}, {30'h0, mux_ch});
            i_masc_host_model.release_sel();
            repeat (4) @(posedge ref_clk);
            check("output released", 33'h1, {32'h0, sdo_oe_n});
            wait_conv(1'b1, n);
            check("restart", 33'h1, {32'h0, n < 8});
            if (i < 3) rd(masc_pkg::REG_RESULT, {1'b0, w}, 32'hffffffff);
            sample <= 30'($urandom);
            len = i[0] ? C50 : C60;
            wait_conv(1'b0, n);
            check("conversion length", 33'h1, {32'h0, n > len - 40 && n <= len});
            $display("test %0d done", i);
        end
        complete_run();
    end
endmodule

`default_nettype wire
